/* core/fslo_top.sv */
// Fail-safe lamp control: emergency, blink and dimming outputs plus development-mode select.
`timescale 1ns/1ps
module fslo_top #(
  parameter int unsigned INIT_TO_CYC = int'(fslo_pkg::INIT_TIMEOUT_CYC),
  parameter int unsigned UV_TO_CYC = int'(fslo_pkg::REG_UV_TIMEOUT_CYC),
  parameter int unsigned BLINK_PERIOD_CYC = int'(fslo_pkg::BLINK_PERIOD_CYC),
  parameter int unsigned BLINK_LOW_CYC = int'(fslo_pkg::BLINK_LOW_CYC),
  parameter int unsigned DIM_PERIOD_CYC = int'(fslo_pkg::DIM_PERIOD_CYC),
  parameter int unsigned DIM_LOW_CYC = int'(fslo_pkg::DIM_LOW_CYC)
) (
  input wire logic clk_sys_in, // System clock, 200 MHz.
  input wire logic rst_b_in, // Power-on reset, asynchronous, active low.
  input wire fslo_pkg::fslo_mode_t mode_in, // Chip mode from the mode controller.
  input wire fslo_pkg::fslo_cmd_t cmd_in, // Serial and watchdog events, one-cycle pulses.
  input wire logic cfg_34_in, // High for watchdog configuration 3/4.
  input wire fslo_pkg::fslo_sense_t sense_in, // Asynchronous comparator and pin levels.
  output logic emergency_pull_b_out, // Emergency output, low pulls the pin low.
  output logic blink_indicator_out, // Blink output, low pulls the pin low.
  output logic dim_or_devsel_pin_out, // Shared pin drive level, always low.
  output logic dim_or_devsel_pin_oe_b_out, // Shared pin enable, low while driving.
  output logic devsel_pullup_en_out, // Shared pin pull-up enable.
  output logic dev_mode_out, // Development mode latched.
  output logic lamp_on_out, // Emergency activation latched.
  output logic uv_timeout_out, // Regulator undervoltage time-out present.
  output logic init_timeout_out // Init time-out expired in this init phase.
);

  fslo_pkg::fslo_sense_t sense_s;
  logic [fslo_pkg::SENSE_W-1:0] sense_vec;

  fslo_pkg::fslo_mode_t mode_prev_ff;
  logic spi_src_ff, fault_src_ff, lamp_on_ff, from_restart_ff, wd_ok_seen_ff;
  logic uv_to_ff, init_to_ff, devsel_low_ff, dev_mode_ff;
  logic emerg_pull_b_ff, pin_oe_b_ff, pullup_ff, pin_level_ff;
  logic [1:0] wd_fail_cnt_ff;
  logic [fslo_pkg::CNT_W-1:0] uv_cnt_ff, init_cnt_ff;

  logic nxt_spi_src, nxt_fault_src, nxt_lamp_on, nxt_from_restart, nxt_wd_ok_seen;
  logic nxt_uv_to, nxt_init_to, nxt_devsel_low, nxt_dev_mode;
  logic nxt_emerg_pull_b, nxt_pin_oe_b, nxt_pullup;
  logic [1:0] nxt_wd_fail_cnt;
  logic [fslo_pkg::CNT_W-1:0] nxt_uv_cnt, nxt_init_cnt;

  logic in_init, in_normal, uv_cond, uv_event, init_event;
  logic wd_event, fault_set, lamp_drive, dim_pull_b;

  fslo_sync #(
    .WIDTH(fslo_pkg::SENSE_W)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(sense_in),
    .reset_val_in('0),
    .sync_out(sense_vec)
  );

  assign sense_s = fslo_pkg::fslo_sense_t'(sense_vec);
  assign in_init = (mode_in == fslo_pkg::FSLO_INIT);
  assign in_normal = (mode_in == fslo_pkg::FSLO_NORMAL);
  assign uv_cond = sense_s.reg_below_rt && sense_s.batt_above_uvgate;
  assign uv_event = uv_cond && (uv_cnt_ff >= fslo_pkg::CNT_W'(UV_TO_CYC));
  assign init_event = in_init && (init_cnt_ff >= fslo_pkg::CNT_W'(INIT_TO_CYC - 1));
  assign lamp_drive = (spi_src_ff || fault_src_ff) && sense_s.batt_above_min;

  // Timers and watchdog failure counting.
  always_comb
  begin
    nxt_uv_cnt = '0;
    nxt_uv_to = 1'b0;
    nxt_init_cnt = '0;
    nxt_init_to = 1'b0;
    nxt_wd_fail_cnt = wd_fail_cnt_ff;
    wd_event = 1'b0;
    if (uv_cond)
    begin
      nxt_uv_to = uv_event;
      nxt_uv_cnt = uv_event ? uv_cnt_ff : uv_cnt_ff + fslo_pkg::CNT_W'(1);
    end
    if (in_init)
    begin
      nxt_init_to = init_to_ff || init_event;
      nxt_init_cnt = init_event ? init_cnt_ff : init_cnt_ff + fslo_pkg::CNT_W'(1);
    end
    if (!in_normal)
      nxt_wd_fail_cnt = '0;
    else if (cmd_in.wd_fail)
    begin
      if (wd_fail_cnt_ff != fslo_pkg::WD_FAIL_LIMIT_CFG34)
        nxt_wd_fail_cnt = wd_fail_cnt_ff + 2'h1;
      wd_event = cfg_34_in ? (nxt_wd_fail_cnt == fslo_pkg::WD_FAIL_LIMIT_CFG34)
                           : (nxt_wd_fail_cnt >= fslo_pkg::WD_FAIL_LIMIT_CFG12);
    end
  end

  // Activation sources and their release; a set always wins over a clear.
  always_comb
  begin
    nxt_spi_src = spi_src_ff;
    nxt_fault_src = fault_src_ff;
    nxt_from_restart = in_normal && (from_restart_ff || (mode_prev_ff == fslo_pkg::FSLO_RESTART));
    nxt_wd_ok_seen = in_normal && (wd_ok_seen_ff || (cmd_in.wd_trig_ok && from_restart_ff));
    // init and off clear, other modes hold except lamp_off in normal
    if (in_init || (mode_in == fslo_pkg::FSLO_OFF))
    begin
      nxt_spi_src = 1'b0;
      nxt_fault_src = 1'b0;
    end
    if (in_normal && cmd_in.lamp_off)
    begin
      nxt_spi_src = 1'b0;
      if (from_restart_ff && wd_ok_seen_ff)
        nxt_fault_src = 1'b0;
    end
    if (in_normal && cmd_in.lamp_on)
      nxt_spi_src = 1'b1;
    fault_set = init_event || (in_normal && wd_event);
    fault_set = fault_set || ((mode_in == fslo_pkg::FSLO_RESTART) && sense_s.reset_short);
    fault_set = fault_set || sense_s.thermal_sd || uv_event;
    fault_set = fault_set || (mode_in == fslo_pkg::FSLO_FAILSAFE);
    if (fault_set)
      nxt_fault_src = 1'b1;
    nxt_lamp_on = nxt_spi_src || nxt_fault_src;
  end

  // Development mode select and pin control.
  always_comb
  begin
    nxt_devsel_low = devsel_low_ff;
    nxt_dev_mode = dev_mode_ff;
    if (in_init && (mode_prev_ff != fslo_pkg::FSLO_INIT))
      nxt_devsel_low = !sense_s.devsel_pin;
    else if (in_init && sense_s.devsel_pin)
      nxt_devsel_low = 1'b0;
    if (!in_init && (mode_prev_ff == fslo_pkg::FSLO_INIT) && devsel_low_ff)
      nxt_dev_mode = 1'b1;
    if ((mode_in == fslo_pkg::FSLO_OFF) || !sense_s.batt_above_off)
      nxt_dev_mode = 1'b0;
    nxt_emerg_pull_b = !lamp_drive;
    nxt_pin_oe_b = in_init || !lamp_drive || dim_pull_b;
    nxt_pullup = in_init;
  end

  fslo_pulse #(
    .PERIOD_CYC(BLINK_PERIOD_CYC),
    .LOW_CYC(BLINK_LOW_CYC)
  ) u_blink (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .run_in(lamp_drive),
    .pull_b_out(blink_indicator_out)
  );

  fslo_pulse #(
    .PERIOD_CYC(DIM_PERIOD_CYC),
    .LOW_CYC(DIM_LOW_CYC)
  ) u_dim (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .run_in(lamp_drive && !in_init),
    .pull_b_out(dim_pull_b)
  );

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_prev_ff <= fslo_pkg::FSLO_OFF;
      spi_src_ff <= 1'b0;
      fault_src_ff <= 1'b0;
      lamp_on_ff <= 1'b0;
      from_restart_ff <= 1'b0;
      wd_ok_seen_ff <= 1'b0;
      wd_fail_cnt_ff <= '0;
      uv_cnt_ff <= '0;
      uv_to_ff <= 1'b0;
      init_cnt_ff <= '0;
      init_to_ff <= 1'b0;
      devsel_low_ff <= 1'b0;
      dev_mode_ff <= 1'b0;
      emerg_pull_b_ff <= 1'b1;
      pin_oe_b_ff <= 1'b1;
      pullup_ff <= 1'b0;
      pin_level_ff <= 1'b0;
    end
    else
    begin
      mode_prev_ff <= mode_in;
      spi_src_ff <= nxt_spi_src;
      fault_src_ff <= nxt_fault_src;
      lamp_on_ff <= nxt_lamp_on;
      from_restart_ff <= nxt_from_restart;
      wd_ok_seen_ff <= nxt_wd_ok_seen;
      wd_fail_cnt_ff <= nxt_wd_fail_cnt;
      uv_cnt_ff <= nxt_uv_cnt;
      uv_to_ff <= nxt_uv_to;
      init_cnt_ff <= nxt_init_cnt;
      init_to_ff <= nxt_init_to;
      devsel_low_ff <= nxt_devsel_low;
      dev_mode_ff <= nxt_dev_mode;
      emerg_pull_b_ff <= nxt_emerg_pull_b;
      pin_oe_b_ff <= nxt_pin_oe_b;
      pullup_ff <= nxt_pullup;
      pin_level_ff <= 1'b0;
    end
  end

  assign emergency_pull_b_out = emerg_pull_b_ff;
  assign dim_or_devsel_pin_out = pin_level_ff;
  assign dim_or_devsel_pin_oe_b_out = pin_oe_b_ff;
  assign devsel_pullup_en_out = pullup_ff;
  assign dev_mode_out = dev_mode_ff;
  assign lamp_on_out = lamp_on_ff;
  assign uv_timeout_out = uv_to_ff;
  assign init_timeout_out = init_to_ff;

  property p_low_batt_release;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !sense_s.batt_above_min |=> emergency_pull_b_out;
  endproperty
  a_low_batt_release: assert property (p_low_batt_release)
    else $error("Emergency output driven below minimum battery.");
  property p_blink_gated;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    emergency_pull_b_out |-> blink_indicator_out;
  endproperty
  a_blink_gated: assert property (p_blink_gated)
    else $error("Blink output pulled while emergency released.");
  property p_init_pin_input;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    in_init |=> dim_or_devsel_pin_oe_b_out && devsel_pullup_en_out;
  endproperty
  a_init_pin_input: assert property (p_init_pin_input)
    else $error("Shared pin driven or pull-up off in init.");
  property p_pullup_outside_init;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !in_init |=> !devsel_pullup_en_out;
  endproperty
  a_pullup_outside_init: assert property (p_pullup_outside_init)
    else $error("Pull-up enabled outside init.");
  property p_dim_needs_emergency;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !dim_or_devsel_pin_oe_b_out |-> !emergency_pull_b_out;
  endproperty
  a_dim_needs_emergency: assert property (p_dim_needs_emergency)
    else $error("Dimming pulse without emergency output.");
  property p_failsafe_on;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (mode_in == fslo_pkg::FSLO_FAILSAFE) ##1 sense_s.batt_above_min |=> !emergency_pull_b_out;
  endproperty
  a_failsafe_on: assert property (p_failsafe_on)
    else $error("Emergency output not asserted in fail-safe.");
  property p_thermal_on;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    sense_s.thermal_sd |=> lamp_on_out;
  endproperty
  a_thermal_on: assert property (p_thermal_on)
    else $error("Thermal shutdown did not activate output.");
  property p_spi_hold;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    spi_src_ff && !cmd_in.lamp_off && !in_init && (mode_in != fslo_pkg::FSLO_OFF)
      |=> spi_src_ff;
  endproperty
  a_spi_hold: assert property (p_spi_hold)
    else $error("Serial activation lost without release command.");
  property p_dev_hold;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    dev_mode_out && sense_s.batt_above_off && (mode_in != fslo_pkg::FSLO_OFF) |=> dev_mode_out;
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("Development mode dropped while battery present.");
  property p_wd_cfg12;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    in_normal && cmd_in.wd_fail && !cfg_34_in |=> lamp_on_out;
  endproperty
  a_wd_cfg12: assert property (p_wd_cfg12)
    else $error("First watchdog failure did not activate output.");
  property p_uv_timeout;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(uv_timeout_out) |-> $past(uv_cond) ##1 lamp_on_out;
  endproperty
  a_uv_timeout: assert property (p_uv_timeout)
    else $error("Undervoltage time-out without cause or activation.");

endmodule

/* core/fslo_pkg.sv */
// Package with modes, signal bundles and timing constants for the fail-safe lamp block.
package fslo_pkg;

  typedef enum logic [2:0] {
    FSLO_OFF,
    FSLO_INIT,
    FSLO_NORMAL,
    FSLO_STOP,
    FSLO_SLEEP,
    FSLO_RESTART,
    FSLO_FAILSAFE,
    FSLO_FLASH
  } fslo_mode_t;

  // Analog comparator and pin levels, all asynchronous to the system clock.
  typedef struct packed {
    logic batt_above_min;
    logic batt_above_uvgate;
    logic batt_above_off;
    logic reg_below_rt;
    logic reset_short;
    logic thermal_sd;
    logic devsel_pin;
  } fslo_sense_t;

  // One-cycle events from the serial and watchdog logic on the system clock.
  typedef struct packed {
    logic lamp_on;
    logic lamp_off;
    logic wd_trig_ok;
    logic wd_fail;
  } fslo_cmd_t;

  localparam int unsigned SENSE_W = $bits(fslo_sense_t);
  localparam int unsigned CNT_W = 32;

  localparam longint unsigned CLK_HZ = 64'd200_000_000;
  localparam longint unsigned MS_PER_S = 64'd1000;
  localparam longint unsigned PCT_FULL = 64'd100;

  localparam longint unsigned INIT_TIMEOUT_MS = 64'd256;
  localparam longint unsigned INIT_TIMEOUT_CYC = INIT_TIMEOUT_MS * CLK_HZ / MS_PER_S;
  localparam longint unsigned REG_UV_TIMEOUT_MS = 64'd1024;
  localparam longint unsigned REG_UV_TIMEOUT_CYC = REG_UV_TIMEOUT_MS * CLK_HZ / MS_PER_S;

  // Blink frequency held in millihertz so that 1.25 Hz stays exact.
  localparam longint unsigned BLINK_FREQ_MHZ = 64'd1250;
  localparam longint unsigned BLINK_DUTY_PCT = 64'd50;
  localparam longint unsigned BLINK_PERIOD_CYC = CLK_HZ * MS_PER_S / BLINK_FREQ_MHZ;
  localparam longint unsigned BLINK_LOW_CYC = BLINK_PERIOD_CYC * BLINK_DUTY_PCT / PCT_FULL;

  localparam longint unsigned DIM_FREQ_HZ = 64'd100;
  localparam longint unsigned DIM_DUTY_PCT = 64'd20;
  localparam longint unsigned DIM_PERIOD_CYC = CLK_HZ / DIM_FREQ_HZ;
  localparam longint unsigned DIM_LOW_CYC = DIM_PERIOD_CYC * DIM_DUTY_PCT / PCT_FULL;

  localparam logic [1:0] WD_FAIL_LIMIT_CFG12 = 2'h1;
  localparam logic [1:0] WD_FAIL_LIMIT_CFG34 = 2'h2;

endpackage

/* core/fslo_sync.sv */
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module fslo_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_b_in, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
  input wire logic [WIDTH-1:0] reset_val_in, // Not used, every stage resets to zero; tie to a constant.
  output logic [WIDTH-1:0] sync_out // Filtered synchronous levels.
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;

endmodule

/* core/fslo_pulse.sv */
// Periodic pull-low pulse generator for an open-drain lamp output.
`timescale 1ns/1ps
module fslo_pulse #(
  parameter int unsigned PERIOD_CYC = 2,
  parameter int unsigned LOW_CYC = 1
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_b_in, // Asynchronous reset, active low.
  input wire logic run_in, // Pulsing enabled.
  output logic pull_b_out // Low while the pin is pulled low.
);

  logic [fslo_pkg::CNT_W-1:0] cnt_ff;
  logic [fslo_pkg::CNT_W-1:0] nxt_cnt;
  logic pull_b_ff;
  logic nxt_pull_b;

  always_comb
  begin
    nxt_cnt = '0;
    nxt_pull_b = 1'b1;
    if (run_in)
    begin
      nxt_pull_b = !(cnt_ff < fslo_pkg::CNT_W'(LOW_CYC));
      if (cnt_ff != fslo_pkg::CNT_W'(PERIOD_CYC - 1))
      begin
        nxt_cnt = cnt_ff + fslo_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_ff <= '0;
      pull_b_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      pull_b_ff <= nxt_pull_b;
    end
  end

  assign pull_b_out = pull_b_ff;

endmodule

/* testbench/fslo_lamp_model.sv */
// Lamp loads and shared-pin strap seen from outside the lamp block.
`timescale 1ns/1ps
module fslo_lamp_model (
  input wire logic emergency_pull_b_in, // Emergency pull-low, active low.
  input wire logic blink_pull_b_in, // Blink pull-low, active low.
  input wire logic pin_drive_in, // Shared pin drive level.
  input wire logic pin_oe_b_in, // Shared pin enable, low while driven.
  input wire logic pin_grounded_in, // Strap from the shared pin to ground.
  output logic emergency_lamp_out, // Emergency line level.
  output logic blink_lamp_out, // Blink line level.
  output logic pin_level_out // Shared pin level.
);
  assign emergency_lamp_out = emergency_pull_b_in ? 1'b1 : 1'b0;
  assign blink_lamp_out = blink_pull_b_in ? 1'b1 : 1'b0;
  assign pin_level_out = !pin_oe_b_in ? pin_drive_in : (pin_grounded_in ? 1'b0 : 1'b1);
endmodule

/* testbench/fslo_top_bench.sv */
// Self-checking bench for the fail-safe lamp block.
`timescale 1ns/1ps
module fslo_top_bench;
  localparam int INIT_TO = 20;
  localparam int UV_TO = 30;
  localparam int BL_P = 20;
  localparam int BL_L = 10;
  localparam int DM_P = 10;
  localparam int DM_L = 2;
  localparam logic [3:0] C_ON = 4'h8;
  localparam logic [3:0] C_OFF = 4'h4;
  localparam logic [3:0] C_TRIG = 4'h2;
  localparam logic [3:0] C_FAIL = 4'h1;
  logic clk_sys_in = 1'b0;
  logic rst_b_in;
  fslo_pkg::fslo_mode_t mode_in;
  fslo_pkg::fslo_cmd_t cmd_in;
  logic cfg_34_in;
  fslo_pkg::fslo_sense_t sns;
  fslo_pkg::fslo_sense_t sense_w;
  logic grounded;
  logic emerg_b, blink_b, pin_drv, pin_oe_b, pullup_en, dev_mode, lamp_on, uv_to, init_to;
  logic emerg_lamp, blink_lamp, pin_level;
  logic seen_to, seen_on, seen_dm;
  int err_total = 0;
  int n_compared = 0;
  int n;

  always #2.5 clk_sys_in = ~clk_sys_in;

  always_comb
  begin
    sense_w = sns;
    sense_w.devsel_pin = pin_level;
  end

  fslo_top #(.INIT_TO_CYC(INIT_TO), .UV_TO_CYC(UV_TO), .BLINK_PERIOD_CYC(BL_P),
    .BLINK_LOW_CYC(BL_L), .DIM_PERIOD_CYC(DM_P), .DIM_LOW_CYC(DM_L)) i_fslo_top (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .mode_in(mode_in), .cmd_in(cmd_in),
    .cfg_34_in(cfg_34_in), .sense_in(sense_w), .emergency_pull_b_out(emerg_b),
    .blink_indicator_out(blink_b), .dim_or_devsel_pin_out(pin_drv),
    .dim_or_devsel_pin_oe_b_out(pin_oe_b), .devsel_pullup_en_out(pullup_en),
    .dev_mode_out(dev_mode), .lamp_on_out(lamp_on), .uv_timeout_out(uv_to),
    .init_timeout_out(init_to));

  fslo_lamp_model i_fslo_lamp_model (
    .emergency_pull_b_in(emerg_b), .blink_pull_b_in(blink_b), .pin_drive_in(pin_drv),
    .pin_oe_b_in(pin_oe_b), .pin_grounded_in(grounded), .emergency_lamp_out(emerg_lamp),
    .blink_lamp_out(blink_lamp), .pin_level_out(pin_level));

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys_in);
  endtask

  task automatic set_mode(input fslo_pkg::fslo_mode_t m);
    @(negedge clk_sys_in);
    mode_in = m;
  endtask

  // Command pulses last exactly one clock cycle.
  task automatic send(input logic [3:0] c);
    @(negedge clk_sys_in);
    cmd_in = c;
    @(negedge clk_sys_in);
    cmd_in = 4'h0;
  endtask

  task automatic lamp(input logic exp_b);
    chk(emerg_b, exp_b, "emergency level");
    chk(emerg_lamp, exp_b, "emergency line");
  endtask

  task automatic wait_lamp(input logic exp_b, input int maxc);
    int i;
    i = 0;
    while (emerg_b !== exp_b && i < maxc)
    begin
      @(negedge clk_sys_in);
      i++;
    end
    lamp(exp_b);
  endtask

  // Any window of one blink period holds the same number of low cycles.
  task automatic lows(input int exp_bl, input int exp_dm);
    int bl;
    int dm;
    bl = 0;
    dm = 0;
    repeat (BL_P)
    begin
      if (blink_lamp === 1'b0) bl++;
      if (pin_level === 1'b0) dm++;
      @(negedge clk_sys_in);
    end
    chk(bl == exp_bl, 1'b1, "blink low count");
    chk(dm == exp_dm, 1'b1, "dim low count");
  endtask

  // A fault still seen through the input synchroniser sets again in off mode.
  task automatic off_clear(input string name);
    set_mode(fslo_pkg::FSLO_OFF);
    cyc(8);
    lamp(1'b1);
    $display("test %s done", name);
  endtask

  initial
  begin
    #(5 * 3000);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    rst_b_in = 1'b0;
    mode_in = fslo_pkg::FSLO_OFF;
    cmd_in = 4'h0;
    cfg_34_in = 1'b0;
    sns = 7'h70;
    grounded = 1'b0;
    cyc(4);
    lamp(1'b1);
    chk(blink_b, 1'b1, "blink in reset");
    chk(pin_oe_b, 1'b1, "pin enable in reset");
    chk(dev_mode, 1'b0, "dev mode in reset");
    rst_b_in = 1'b1;
    grounded = 1'b1;
    set_mode(fslo_pkg::FSLO_INIT);
    cyc(12);
    chk(pullup_en, 1'b1, "pull-up in init");
    chk(pin_oe_b, 1'b1, "pin input in init");
    set_mode(fslo_pkg::FSLO_NORMAL);
    cyc(3);
    chk(dev_mode, 1'b1, "dev mode selected");
    chk(pullup_en, 1'b0, "pull-up off");
    grounded = 1'b0;
    sns.batt_above_off = 1'b0;
    cyc(7);
    chk(dev_mode, 1'b0, "dev mode cleared");
    sns.batt_above_off = 1'b1;
    grounded = 1'b1;
    cyc(4);
    set_mode(fslo_pkg::FSLO_INIT);
    cyc(5);
    grounded = 1'b0;
    cyc(8);
    set_mode(fslo_pkg::FSLO_NORMAL);
    cyc(3);
    chk(dev_mode, 1'b0, "dev mode needs whole init low");
    off_clear("devsel");
    set_mode(fslo_pkg::FSLO_SLEEP);
    send(C_ON);
    cyc(3);
    lamp(1'b1);
    set_mode(fslo_pkg::FSLO_NORMAL);
    send(C_ON);
    cyc(1);
    chk(lamp_on, 1'b1, "serial activation");
    cyc(1);
    lamp(1'b0);
    lows(BL_L, DM_L * BL_P / DM_P);
    set_mode(fslo_pkg::FSLO_STOP);
    send(C_OFF);
    cyc(3);
    lamp(1'b0);
    set_mode(fslo_pkg::FSLO_NORMAL);
    send(C_OFF);
    cyc(2);
    lamp(1'b1);
    lows(0, 0);
    off_clear("serial");
    set_mode(fslo_pkg::FSLO_NORMAL);
    send(C_FAIL);
    cyc(3);
    lamp(1'b0);
    send(C_OFF);
    cyc(3);
    lamp(1'b0);
    set_mode(fslo_pkg::FSLO_RESTART);
    cyc(3);
    lamp(1'b0);
    set_mode(fslo_pkg::FSLO_NORMAL);
    cyc(2);
    send(C_OFF);
    cyc(3);
    lamp(1'b0);
    send(C_TRIG);
    cyc(3);
    lamp(1'b0);
    send(C_OFF);
    cyc(3);
    lamp(1'b1);
    cfg_34_in = 1'b1;
    send(C_FAIL);
    cyc(3);
    lamp(1'b1);
    send(C_FAIL);
    cyc(3);
    lamp(1'b0);
    off_clear("watchdog");
    seen_to = 1'b0;
    seen_on = 1'b0;
    seen_dm = 1'b0;
    set_mode(fslo_pkg::FSLO_INIT);
    repeat (INIT_TO + 6)
    begin
      @(negedge clk_sys_in);
      seen_to |= init_to;
      seen_on |= lamp_on;
      seen_dm |= ~pin_oe_b;
    end
    chk(seen_to, 1'b1, "init time-out");
    chk(seen_on, 1'b1, "init time-out activation");
    chk(seen_dm, 1'b0, "dim inhibited in init");
    off_clear("init time-out");
    set_mode(fslo_pkg::FSLO_RESTART);
    sns.reset_short = 1'b1;
    wait_lamp(1'b0, 10);
    sns.reset_short = 1'b0;
    off_clear("reset short");
    set_mode(fslo_pkg::FSLO_SLEEP);
    sns.thermal_sd = 1'b1;
    wait_lamp(1'b0, 10);
    sns.thermal_sd = 1'b0;
    off_clear("thermal");
    sns.batt_above_min = 1'b0;
    set_mode(fslo_pkg::FSLO_FAILSAFE);
    cyc(8);
    chk(lamp_on, 1'b1, "fail-safe activation");
    lamp(1'b1);
    sns.batt_above_min = 1'b1;
    wait_lamp(1'b0, 10);
    off_clear("low battery");
    set_mode(fslo_pkg::FSLO_NORMAL);
    sns.reg_below_rt = 1'b1;
    sns.batt_above_uvgate = 1'b0;
    cyc(UV_TO + 15);
    chk(uv_to, 1'b0, "no time-out when battery low");
    sns.batt_above_uvgate = 1'b1;
    n = 0;
    while (uv_to !== 1'b1 && n < UV_TO + 20)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n >= UV_TO && n <= UV_TO + 8, 1'b1, "undervoltage time-out length");
    wait_lamp(1'b0, 4);
    sns.reg_below_rt = 1'b0;
    off_clear("undervoltage");
    end_of_test();
  end
endmodule
